//--- logic/epsw_defs.svh
// Constants of the encoder position status word block
`ifndef EPSW_DEFS_SVH
`define EPSW_DEFS_SVH

// Attribute numbers
`define EPSW_ATTR_INDEX   8'h6e
`define EPSW_ATTR_CHAN    8'h6f
`define EPSW_ATTR_STATUS  8'h70

// Read-only attribute values (index value is arbitrary)
`define EPSW_INDEX_VAL    8'h00
`define EPSW_CHAN_VAL     8'h01

// Status word bit positions
`define EPSW_B_GROUP      0
`define EPSW_B_FAULT      1
`define EPSW_B_UPPER      2
`define EPSW_B_LOWER      3
`define EPSW_B_PARAM      4
`define EPSW_B_SUSP       7
`define EPSW_B_EQ1        8
`define EPSW_B_FLAG1      9
`define EPSW_B_GE1        10
`define EPSW_B_EQ2        11
`define EPSW_B_FLAG2      12
`define EPSW_B_GE2        13
`define EPSW_B_DOWN       14
`define EPSW_B_UP         15

// Position width and link timing
`define EPSW_POS_W        24
`define EPSW_CLK_NS       40
`define EPSW_HALF_NS      160
`define EPSW_PAUSE_NS     30000
`define EPSW_HALF_CYC     ((`EPSW_HALF_NS + `EPSW_CLK_NS - 1) / `EPSW_CLK_NS)
`define EPSW_PAUSE_CYC    ((`EPSW_PAUSE_NS + `EPSW_CLK_NS - 1) / `EPSW_CLK_NS)

`endif

//--- logic/epsw_pkg.sv
// Types of the encoder position status word block
`include "epsw_defs.svh"

package epsw_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LO,
    ST_HI
  } epsw_state_e;

  typedef logic [`EPSW_POS_W-1:0] epsw_pos_t;

  typedef struct packed {
    epsw_state_e state;
    logic [15:0] cnt;
    logic [5:0]  bits;
    epsw_pos_t   shreg;
    epsw_pos_t   encoder_position_value;
    logic        have_pos;
    logic        fault;
    logic        dir_up;
    logic        dir_dn;
    logic        sclk;
    logic        din_meta;
    logic        din_sync;
    logic        rd_valid;
    logic        rd_err;
    logic [15:0] rd_data;
  } epsw_main_s;

  typedef struct packed {
    logic eq;
    logic ge;
    logic flag;
  } epsw_cmp_s;

endpackage

//--- logic/epsw_cmp.sv
// Position comparator with equal, greater-or-equal and sticky match flag
`timescale 1ns/100ps
`default_nettype none

module epsw_cmp
  import epsw_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Operands
  input  wire logic      valid_i,
  input  wire epsw_pos_t pos_i,
  input  wire epsw_pos_t cmp_i,
  input  wire logic      clr_i,
  // Results
  output logic           eq_o,
  output logic           ge_o,
  output logic           flag_o
);

  epsw_cmp_s s;
  epsw_cmp_s next_s;

  always_comb begin
    next_s      = s;
    next_s.eq   = valid_i && (pos_i == cmp_i);
    next_s.ge   = valid_i && (pos_i >= cmp_i);
    // Set wins over a clear in the same cycle
    if (clr_i) begin
      next_s.flag = 1'b0;
    end
    if (next_s.eq) begin
      next_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign eq_o   = s.eq;
  assign ge_o   = s.ge;
  assign flag_o = s.flag;

endmodule // epsw_cmp

`default_nettype wire

//--- logic/epsw_status.sv
// Encoder polling and diagnostics status word with attribute read port
// Summary of operation
// RQ1: Bit 0 ORs all enabled status signals
// RQ2: Bit 1 flags faulty encoder line
// RQ3: Bit 2 set when position above upper bound
// RQ4: Bit 3 set when position below lower bound
// RQ5: Bit 4 reports parameter set fault
// RQ6: Bits 5 and 6 reserved, read zero
// RQ7: Poll cyclically, bit 7 zero when running
// RQ8: Stop or parameter fault suspends, sets bit 7
// RQ9: Bit 8 set while position equals compare one
// RQ10: Bit 9 sticky match one, host clears
// RQ11: Bit 10 position at least compare one
// RQ12: Bit 11 set while position equals compare two
// RQ13: Read-only supported channel count
// RQ14: Bit 12 sticky match two, host clears
// RQ15: Bit 13 position at least compare two
// RQ16: Bits 14 and 15 show travel direction
// RQ17: Status re-evaluated on each captured sample
`timescale 1ns/100ps
`default_nettype none
`include "epsw_defs.svh"

module epsw_status
  import epsw_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Encoder link
  output logic             link_clk_o,
  input  wire logic        link_data_i,
  // Process and parameter control
  input  wire logic        stop_i,
  input  wire logic        parameter_fault_i,
  input  wire logic [15:1] enabled_status_signals_i,
  input  wire epsw_pos_t   upper_position_bound_i,
  input  wire epsw_pos_t   lower_position_bound_i,
  input  wire epsw_pos_t   first_compare_value_i,
  input  wire epsw_pos_t   second_compare_value_i,
  input  wire logic        clr_first_flag_i,
  input  wire logic        clr_second_flag_i,
  // Attribute read port
  input  wire logic        attr_rd_i,
  input  wire logic [7:0]  attr_num_i,
  output logic             attr_valid_o,
  output logic             attr_err_o,
  output logic [15:0]      attr_data_o
);

  epsw_main_s  s;
  epsw_main_s  next_s;
  logic        susp;
  logic        eq1;
  logic        ge1;
  logic        flag1;
  logic        eq2;
  logic        ge2;
  logic        flag2;
  logic [15:0] word;
  epsw_pos_t   sample;

  assign susp   = stop_i || parameter_fault_i; // RQ8
  assign sample = {s.shreg[`EPSW_POS_W-2:0], s.din_sync};

  epsw_cmp u_cmp1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (s.have_pos),
    .pos_i   (s.encoder_position_value),
    .cmp_i   (first_compare_value_i),
    .clr_i   (clr_first_flag_i),
    .eq_o    (eq1),
    .ge_o    (ge1),
    .flag_o  (flag1)
  );

  epsw_cmp u_cmp2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .valid_i (s.have_pos),
    .pos_i   (s.encoder_position_value),
    .cmp_i   (second_compare_value_i),
    .clr_i   (clr_second_flag_i),
    .eq_o    (eq2),
    .ge_o    (ge2),
    .flag_o  (flag2)
  );

  always_comb begin
    word                 = 16'h0000;
    word[`EPSW_B_FAULT]  = s.fault; // RQ2
    word[`EPSW_B_UPPER]  = s.have_pos
                           && (s.encoder_position_value > upper_position_bound_i); // RQ3
    word[`EPSW_B_LOWER]  = s.have_pos
                           && (s.encoder_position_value < lower_position_bound_i); // RQ4
    word[`EPSW_B_PARAM]  = parameter_fault_i; // RQ5
    word[`EPSW_B_SUSP]   = susp; // RQ7
    word[`EPSW_B_EQ1]    = eq1; // RQ9
    word[`EPSW_B_FLAG1]  = flag1; // RQ10
    word[`EPSW_B_GE1]    = ge1; // RQ11
    word[`EPSW_B_EQ2]    = eq2; // RQ12
    word[`EPSW_B_FLAG2]  = flag2; // RQ14
    word[`EPSW_B_GE2]    = ge2; // RQ15
    word[`EPSW_B_DOWN]   = s.dir_dn; // RQ16
    word[`EPSW_B_UP]     = s.dir_up; // RQ16
    // Bits 5 and 6 stay zero
    word[`EPSW_B_GROUP]  = |(word[15:1] & enabled_status_signals_i); // RQ1 RQ6
  end

  always_comb begin
    next_s          = s;
    next_s.din_meta = link_data_i;
    next_s.din_sync = s.din_meta;
    next_s.rd_valid = attr_rd_i;
    next_s.rd_err   = 1'b0;
    next_s.rd_data  = 16'h0000;
    if (attr_rd_i) begin
      case (attr_num_i)
        `EPSW_ATTR_INDEX:  next_s.rd_data = {8'h00, `EPSW_INDEX_VAL};
        `EPSW_ATTR_CHAN:   next_s.rd_data = {8'h00, `EPSW_CHAN_VAL}; // RQ13
        `EPSW_ATTR_STATUS: next_s.rd_data = word;
        default:           next_s.rd_err  = 1'b1;
      endcase
    end
    case (s.state)
      ST_IDLE: begin
        next_s.sclk = 1'b1;
        if (s.cnt != 16'h0000) begin
          next_s.cnt = s.cnt - 16'h0001;
        end else if (!susp) begin // RQ7 RQ8
          if (!s.din_sync) begin
            // Idle line must sit high; low means broken cable
            next_s.fault = 1'b1; // RQ2
            next_s.cnt   = 16'(`EPSW_PAUSE_CYC - 1);
          end else begin
            next_s.state = ST_LO;
            next_s.sclk  = 1'b0;
            next_s.cnt   = 16'(`EPSW_HALF_CYC - 1);
            next_s.bits  = 6'(`EPSW_POS_W);
          end
        end
      end
      ST_LO: begin
        if (s.cnt != 16'h0000) begin
          next_s.cnt = s.cnt - 16'h0001;
        end else begin
          next_s.state = ST_HI;
          next_s.sclk  = 1'b1;
          next_s.cnt   = 16'(`EPSW_HALF_CYC - 1);
        end
      end
      ST_HI: begin
        if (s.cnt != 16'h0000) begin
          next_s.cnt = s.cnt - 16'h0001;
        end else begin
          // Sample just before the next falling edge for settled data
          next_s.shreg = sample;
          next_s.bits  = s.bits - 6'h01;
          if (s.bits == 6'h01) begin
            next_s.encoder_position_value = sample; // RQ17
            next_s.have_pos = 1'b1;
            next_s.fault    = 1'b0;
            next_s.dir_up   = s.have_pos && (sample > s.encoder_position_value); // RQ16
            next_s.dir_dn   = s.have_pos && (sample < s.encoder_position_value); // RQ16
            next_s.state    = ST_IDLE;
            next_s.cnt      = 16'(`EPSW_PAUSE_CYC - 1);
          end else begin
            next_s.state = ST_LO;
            next_s.sclk  = 1'b0;
            next_s.cnt   = 16'(`EPSW_HALF_CYC - 1);
          end
        end
      end
      default: begin
        next_s.state = ST_IDLE;
        next_s.sclk  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s          <= '0;
      s.sclk     <= 1'b1;
      // Sync flops start at the idle line level, else a false fault follows reset
      s.din_meta <= 1'b1;
      s.din_sync <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link_clk_o   = s.sclk;
  assign attr_valid_o = s.rd_valid;
  assign attr_err_o   = s.rd_err;
  assign attr_data_o  = s.rd_data;

  status_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    attr_rd_i && attr_num_i == `EPSW_ATTR_STATUS |=> attr_valid_o && attr_data_o == $past(word))
    else $error("status read returned wrong word");

  group_bit_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
    (s.fault && enabled_status_signals_i[`EPSW_B_FAULT]) |-> word[`EPSW_B_GROUP])
    else $error("group bit missing");

  line_fault_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
    s.state == ST_IDLE && s.cnt == 16'h0000 && !susp && !s.din_sync |=> s.fault)
    else $error("line fault not flagged");

  limit_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
    s.have_pos |-> word[`EPSW_B_UPPER] == (s.encoder_position_value > upper_position_bound_i)
                && word[`EPSW_B_LOWER] == (s.encoder_position_value < lower_position_bound_i))
    else $error("limit bit wrong");

  reserved_bits_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
    word[6:5] == 2'b00)
    else $error("reserved bits set");

  suspend_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
    s.state == ST_IDLE && susp |=> s.state == ST_IDLE && link_clk_o)
    else $error("link ran while suspended");

  equal_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
    s.have_pos && $stable(s.encoder_position_value) && $stable(first_compare_value_i)
    && s.encoder_position_value == first_compare_value_i |=> eq1 && flag1)
    else $error("compare one match missed");

  sticky_one_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
    flag1 && !clr_first_flag_i |=> flag1)
    else $error("sticky flag one lost");

  sticky_two_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
    flag2 && !clr_second_flag_i |=> flag2)
    else $error("sticky flag two lost");

  chan_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
    attr_rd_i && attr_num_i == `EPSW_ATTR_CHAN |=> attr_data_o == {8'h00, `EPSW_CHAN_VAL})
    else $error("channel count wrong");

  direction_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
    !(s.dir_up && s.dir_dn))
    else $error("both directions set");

  capture_a: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17
    s.state == ST_HI && s.cnt == 16'h0000 && s.bits == 6'h01
    |=> s.have_pos && s.state == ST_IDLE && s.encoder_position_value == $past(sample))
    else $error("sample not captured");

endmodule // epsw_status

`default_nettype wire

//--- verif/epsw_enc.sv
// Behavioural absolute encoder on the serial link
`timescale 1ns/100ps
`default_nettype none

module epsw_enc
  import epsw_pkg::*;
(
  // Link
  input  wire logic      lclk_i,
  output logic           data_o,
  // Control
  input  wire epsw_pos_t pos_i,
  input  wire logic      brk_i,
  output int             done_o
);
  logic d;

  // Broken cable holds the line low
  assign data_o = brk_i ? 1'b0 : d;

  // One process owns the line, so no two drivers fight over it
  initial begin
    d      = 1'b1;
    done_o = 0;
    forever begin
      // Each falling link edge shifts out the next bit, MSB first
      for (int k = 23; k >= 0; k--) begin
        @(negedge lclk_i);
        d = pos_i[k];
      end
      @(posedge lclk_i);
      done_o = done_o + 1;
      // Last bit held past the sampling point, then idle high
      #400 d = 1'b1;
    end
  end
endmodule // epsw_enc

`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench of the status word block
`timescale 1ns/100ps
`default_nettype none

module testbench
  import epsw_pkg::*;
();
  logic        clk_i = 0, rst_i = 1, stop_i = 1, pf = 0, brk = 0;
  logic        rd = 0, clr1 = 0, clr2 = 0, lclk, ldat, vld, err;
  logic        f1 = 0, f2 = 0, flt = 0, hv = 0;
  logic [15:1] msk;
  logic [7:0]  num = 8'h00;
  logic [15:0] dat;
  epsw_pos_t   up, lo, c1, c2, ep, pos, prv;
  int          done, err_count = 0, n_checks = 0;
  logic [16:0] q[$];

  epsw_status dut (.clk_i(clk_i), .rst_i(rst_i), .link_clk_o(lclk), .link_data_i(ldat),
    .stop_i(stop_i), .parameter_fault_i(pf), .enabled_status_signals_i(msk),
    .upper_position_bound_i(up), .lower_position_bound_i(lo),
    .first_compare_value_i(c1), .second_compare_value_i(c2),
    .clr_first_flag_i(clr1), .clr_second_flag_i(clr2), .attr_rd_i(rd),
    .attr_num_i(num), .attr_valid_o(vld), .attr_err_o(err), .attr_data_o(dat));
  epsw_enc enc (.lclk_i(lclk), .data_o(ldat), .pos_i(ep), .brk_i(brk), .done_o(done));

  initial forever #20 clk_i = ~clk_i;

  function automatic logic [16:0] ew();
    logic [15:0] w;
    w = 16'h0000;
    w[1] = flt;
    w[4] = pf;
    w[7] = stop_i | pf;
    // Compare and limit bits are zero until a first sample
    if (hv) begin
      w[2] = pos > up;
      w[3] = pos < lo;
      w[8] = pos == c1;
      w[9] = f1;
      w[10] = pos >= c1;
      w[11] = pos == c2;
      w[12] = f2;
      w[13] = pos >= c2;
      w[14] = pos < prv;
      w[15] = pos > prv;
    end
    w[0] = |(w[15:1] & msk);
    return {1'b0, w};
  endfunction

  task automatic rd_attr(input logic [7:0] n, input logic [16:0] e);
    @(negedge clk_i);
    rd = 1'b1;
    num = n;
    q.push_back(e);
    @(negedge clk_i);
    rd = 1'b0;
  endtask

  // Lets exactly one frame through, then suspends polling again
  task automatic frm(input epsw_pos_t p, input bit r);
    int n;
    n = done;
    ep = p;
    @(negedge clk_i);
    stop_i = 1'b0;
    if (r) rd_attr(8'h70, ew());
    for (int i = 0; i < 4000 && done == n; i++) @(negedge clk_i);
    if (done == n) begin
      err_count++;
      $display("ERROR %0t frames %h exp %h", $time, done, n + 1);
    end
    stop_i = 1'b1;
    repeat (40) @(negedge clk_i);
    prv = pos;
    pos = p;
    hv = 1'b1;
    flt = 1'b0;
    if (p == c1) f1 = 1'b1;
    if (p == c2) f2 = 1'b1;
  endtask

  task automatic test_done();
    repeat (4) @(negedge clk_i);
    if (q.size() != 0) err_count++;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(negedge clk_i) begin
    if (vld === 1'b1) begin
      n_checks++;
      if (q.size() == 0 || {err, dat} !== q[0]) begin
        err_count++;
        $display("ERROR %0t got %h exp %h", $time, {err, dat}, q.size() ? q[0] : 17'h0_0000);
      end
      if (q.size() != 0) void'(q.pop_front());
    end
  end

  initial begin
    #(40000 * 40);
    err_count++;
    test_done();
  end

  initial begin
    void'($urandom(30));
    msk = 15'($urandom);
    c1 = 24'($urandom_range(24'h7F_0000, 24'h00_1000));
    c2 = c1 + 24'h00_0064;
    lo = c1 + 24'h00_0001;
    up = c1 + 24'h00_0032;
    ep = c1 + 24'h00_0005;
    pos = 24'h00_0000;
    prv = 24'h00_0000;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    rd_attr(8'h6e, 17'h0_0000);
    rd_attr(8'h6f, 17'h0_0001);
    rd_attr(8'h55, 17'h1_0000);
    $display("test attributes done");
    frm(c1 + 24'h00_0005, 1);
    frm(c1 + 24'h00_0005, 0);
    frm(c1, 1);
    rd_attr(8'h70, ew());
    pf = 1'b1;
    rd_attr(8'h70, ew());
    pf = 1'b0;
    frm(c2, 1);
    rd_attr(8'h70, ew());
    $display("test compares done");
    brk = 1'b1;
    stop_i = 1'b0;
    // Outlast the pause after the last frame so the line check runs
    repeat (800) @(negedge clk_i);
    stop_i = 1'b1;
    flt = 1'b1;
    rd_attr(8'h70, ew());
    brk = 1'b0;
    frm(c1 + 24'h00_003c, 1);
    rd_attr(8'h70, ew());
    @(negedge clk_i);
    clr1 = 1'b1;
    clr2 = 1'b1;
    @(negedge clk_i);
    clr1 = 1'b0;
    clr2 = 1'b0;
    f1 = 1'b0;
    f2 = 1'b0;
    rd_attr(8'h70, ew());
    $display("test fault and clear done");
    for (int j = 0; j < 4; j++) begin
      msk = 15'($urandom);
      frm(c1 - 24'h00_000a + 24'($urandom_range(0, 120)), 1);
      rd_attr(8'h70, ew());
    end
    $display("test random positions done");
    test_done();
  end
endmodule // testbench

`default_nettype wire
